// ==== verilog/atx_pkg.sv ====
package atx_pkg;

  // ==========================================================
  // command and response codes
  localparam logic [7:0] CMD_SWITCH   = 8'h1c;
  localparam logic [7:0] CMD_WATCHDOG = 8'h1d;
  localparam logic [7:0] CMD_STATUS   = 8'h1e;
  localparam logic [7:0] RESP_SWITCH   = 8'h5c;
  localparam logic [7:0] RESP_WATCHDOG = 8'h5d;
  localparam logic [7:0] RESP_STATUS   = 8'h5e;
  localparam logic [7:0] RESP_ERROR_BIT = 8'h80; // or-ed onto an unknown code

  // ==========================================================
  // function mask bit positions
  localparam int BIT_AUTO_POLARITY = 0;
  localparam int BIT_RESET_INVERT  = 1;
  localparam int BIT_POWER_INVERT  = 2;
  localparam int BIT_LEDS_TRACK    = 3; // leds_track_host_off
  localparam int BIT_BLANK_HOST    = 4; // blank_when_host_off
  localparam int BIT_KEY_RESET     = 5;
  localparam int BIT_KEY_POWER_ON  = 6;
  localparam int BIT_KEY_POWER_OFF = 7;

  // ==========================================================
  // reset values
  localparam logic [7:0] MASK_RESET  = 8'h00;
  localparam logic [7:0] PULSE_RESET = 8'hff;
  localparam logic [7:0] PULSE_HOLD  = 8'hff; // hold until sense change

  // ==========================================================
  // timing: clock and tick period in ns, hold and pulse lengths in 1/32 second ticks
  localparam int CLK_PERIOD_NS  = 8;
  localparam int TICK_NS        = 31_250_000;
  localparam int TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W         = 22;
  localparam logic [7:0] HOLD_LONG_TICKS  = 8'd128; // 4 s
  localparam logic [7:0] HOLD_SHORT_TICKS = 8'd8;   // 0.25 s
  localparam logic [8:0] RESET_TICKS      = 9'd32;  // 1 s
  localparam logic [8:0] HOLD_MAX_TICKS   = 9'd256; // 8 s
  localparam logic [7:0] EXTEND_TICKS     = 8'd160; // 5 s
  localparam logic [4:0] TICKS_PER_SEC_M1 = 5'd31;

  // ==========================================================
  // register indices on the software port
  localparam logic [5:0] REG_CMD        = 6'h00;
  localparam logic [5:0] REG_ARG0       = 6'h01;
  localparam logic [5:0] REG_ARG1       = 6'h02;
  localparam logic [5:0] REG_ARGCNT     = 6'h03;
  localparam logic [5:0] REG_RESP       = 6'h04;
  localparam logic [5:0] REG_BOOT_MASK  = 6'h05;
  localparam logic [5:0] REG_BOOT_PULSE = 6'h06;
  localparam logic [5:0] REG_STATE      = 6'h07;
  localparam logic [5:0] REG_STAT_BASE  = 6'h10;
  localparam logic [5:0] STAT_BYTES     = 6'd15;
  localparam logic [5:0] STAT_MASK_IDX  = 6'd7;
  localparam logic [5:0] STAT_WDOG_IDX  = 6'd8;

  // pin configuration byte layout
  localparam int         PINCFG_FUNC_BIT = 3;
  localparam logic [2:0] DRIVE_PULLUP    = 3'b011;
  localparam logic [2:0] DRIVE_HIZ       = 3'b010;

  // sequencer phases
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_RESET,
    PH_POWER,
    PH_RESTART
  } phase_t;

endpackage

// ==== verilog/input_sync.sv ====
`timescale 1ns/1ns
module input_sync
  import atx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [4:0] async,
  output logic      [4:0] synced
);

  // two-stage synchroniser state
  typedef struct packed {
    logic [4:0] stage1; // metastable stage, read only by stage2
    logic [4:0] stage2; // settled copy
  } sync_t;

  sync_t q;
  sync_t d;

  // ==========================================================
  // next state
  always_comb
  begin
    d        = q;
    d.stage1 = async;
    d.stage2 = q.stage1;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign synced = q.stage2;

endmodule

// ==== verilog/atx_power_switch_watchdog.sv ====
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
module atx_power_switch_watchdog
  import atx_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES // cycles per 1/32 s tick
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [5:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrEn,
  input  wire logic       rdEn,
  output logic      [7:0] rdData,
  input  wire logic       hostSense,
  input  wire logic       keyConfirm,
  input  wire logic       keyCancel,
  input  wire logic       resetIn,
  output logic            resetOut,
  output logic            resetOe,
  input  wire logic       powerIn,
  output logic            powerOut,
  output logic            powerOe,
  output logic            displayDark,
  output logic            backlightOff,
  output logic            ledsOff,
  output logic            selfRestart
);

  // ==========================================================
  // state
  typedef struct packed {
    phase_t            phase;        // sequencer phase
    logic [7:0]        cfgMask;      // active function mask
    logic [7:0]        pulseLen;     // active power pulse length
    logic [7:0]        bootMask;     // saved boot mask
    logic [7:0]        bootPulse;    // saved boot pulse length
    logic [7:0]        arg0;         // command data byte 0
    logic [7:0]        arg1;         // command data byte 1
    logic [1:0]        argCnt;       // number of data bytes
    logic [7:0]        resp;         // last response type
    logic [7:0]        wdTimeout;    // watchdog timeout, 0 = off
    logic [7:0]        wdCount;      // seconds left
    logic [4:0]        wdSub;        // ticks within a second
    logic [TICK_W-1:0] tickCnt;      // prescaler
    logic [7:0]        confirmCnt;   // confirm key held ticks
    logic [7:0]        cancelCnt;    // cancel key held ticks
    logic [8:0]        pulseCnt;     // ticks left in pulse
    logic [7:0]        extendCnt;    // ticks of extension used
    logic              holdMode;     // pulse waits for sense change
    logic              extendOk;     // pulse may be extended
    logic              restartAfter; // restart when pulse ends
    logic              senseAtStart; // sense level at pulse start
    logic              senseLast;    // sense of previous cycle
    logic [7:0]        rdData;
    logic              resetOut;
    logic              resetOe;
    logic              powerOut;
    logic              powerOe;
    logic              displayDark;
    logic              backlightOff;
    logic              ledsOff;
    logic              selfRestart;
  } state_t;

  state_t q;
  state_t d;

  logic [4:0] syncIn;      // synchronised pins
  logic       sense;       // host power sense
  logic       confirmKey;  // confirm key held
  logic       cancelKey;   // cancel key held
  logic       resetLine;   // reset line level
  logic       powerLine;   // power line level
  logic       tick;        // 1/32 s strobe
  logic       cmdGo;       // command write accepted
  logic       drvLevel;    // level chosen for a pulse

  // ==========================================================
  // pin synchroniser
  input_sync u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .async  ({powerIn, resetIn, keyCancel, keyConfirm, hostSense}),
    .synced (syncIn)
  );

  assign sense      = syncIn[0];
  assign confirmKey = syncIn[1];
  assign cancelKey  = syncIn[2];
  assign resetLine  = syncIn[3];
  assign powerLine  = syncIn[4];

  // ==========================================================
  // read decode
  function automatic logic [7:0] regRead(input logic [5:0] a, input state_t s);
    logic [5:0] idx;
    idx = a - REG_STAT_BASE;
    if (a == REG_ARG0)
      regRead = s.arg0;
    else if (a == REG_ARG1)
      regRead = s.arg1;
    else if (a == REG_ARGCNT)
      regRead = {6'h00, s.argCnt};
    else if (a == REG_RESP)
      regRead = s.resp;
    else if (a == REG_BOOT_MASK)
      regRead = s.bootMask;
    else if (a == REG_BOOT_PULSE)
      regRead = s.bootPulse;
    else if (a == REG_STATE)
      regRead = {5'h00, sense, s.phase};
    else if (a >= REG_STAT_BASE && idx < STAT_BYTES)
    begin
      // fan, temperature, key, glitch, contrast bytes live elsewhere
      if (idx == STAT_MASK_IDX)
        regRead = s.cfgMask;
      else if (idx == STAT_WDOG_IDX)
        regRead = s.wdCount;
      else
        regRead = 8'h00;
    end
    else
      regRead = 8'h00; // unmapped and write-only read as zero
  endfunction

  // ==========================================================
  // next state
  always_comb
  begin
    d           = q;
    tick        = 1'b0;
    cmdGo       = 1'b0;
    drvLevel    = 1'b0;
    d.selfRestart = 1'b0;
    d.senseLast = sense;

    // prescaler for the 1/32 s tick
    if (q.tickCnt >= TICK_W'(TICK_CYC - 1))
    begin
      d.tickCnt = '0;
      tick      = 1'b1;
    end
    else
    begin
      d.tickCnt = q.tickCnt + TICK_W'(1);
    end

    // read data stands only in the cycle after the strobe
    d.rdData = rdEn ? regRead(addr, q) : 8'h00;

    // register writes
    if (wrEn)
    begin
      unique case (addr)
        REG_ARG0:       d.arg0 = wrData;
        REG_ARG1:       d.arg1 = wrData;
        REG_ARGCNT:     d.argCnt = wrData[1:0];
        REG_BOOT_MASK:  d.bootMask = wrData;
        REG_BOOT_PULSE: d.bootPulse = wrData;
        REG_CMD:        cmdGo = (q.phase == PH_IDLE);
        default:        ;
      endcase
    end

    // key hold counters keep running in every phase except PH_RESTART, which clears them
    if (tick)
    begin
      d.confirmCnt = !confirmKey ? 8'h00 :
                     (q.confirmCnt == 8'hff) ? q.confirmCnt : q.confirmCnt + 8'h01;
      d.cancelCnt  = !cancelKey ? 8'h00 :
                     (q.cancelCnt == 8'hff) ? q.cancelCnt : q.cancelCnt + 8'h01;
    end

    // watchdog countdown in whole seconds
    if (q.wdTimeout != 8'h00 && q.wdCount != 8'h00 && tick)
    begin
      if (q.wdSub == TICKS_PER_SEC_M1)
      begin
        d.wdSub   = 5'h00;
        d.wdCount = q.wdCount - 8'h01;
      end
      else
      begin
        d.wdSub = q.wdSub + 5'h01;
      end
    end

    // command execution
    if (cmdGo)
    begin
      if (wrData == CMD_SWITCH)
      begin
        d.cfgMask = q.arg0;
        if (q.argCnt >= 2'd2)
          d.pulseLen = q.arg1;
        d.resp = RESP_SWITCH;
      end
      else if (wrData == CMD_WATCHDOG)
      begin
        d.wdTimeout = q.arg0;
        d.wdCount   = q.arg0;
        d.wdSub     = 5'h00;
        d.resp      = RESP_WATCHDOG;
      end
      else if (wrData == CMD_STATUS)
        d.resp = RESP_STATUS;
      else
        d.resp = wrData | RESP_ERROR_BIT;
    end

    // display follows host power when blanking is on
    d.displayDark  = q.cfgMask[BIT_BLANK_HOST] && !sense;
    d.backlightOff = q.cfgMask[BIT_BLANK_HOST] && !sense;
    d.ledsOff      = q.cfgMask[BIT_BLANK_HOST] && q.cfgMask[BIT_LEDS_TRACK]
                     && !sense;

    // sequencer
    unique case (q.phase)
      PH_IDLE:
      begin
        if (q.wdTimeout != 8'h00 && q.wdCount == 8'h00 && !cmdGo)
        begin
          // watchdog expired: host reset, then restart
          drvLevel       = q.cfgMask[BIT_AUTO_POLARITY] ? !resetLine
                           : q.cfgMask[BIT_RESET_INVERT];
          d.phase        = PH_RESET;
          d.pulseCnt     = RESET_TICKS;
          d.restartAfter = 1'b1;
          d.resetOut     = drvLevel;
          d.resetOe      = 1'b1;
        end
        else if (q.cfgMask[BIT_KEY_RESET] && sense && confirmKey && tick
                 && q.confirmCnt == HOLD_LONG_TICKS - 8'h01)
        begin
          drvLevel       = q.cfgMask[BIT_AUTO_POLARITY] ? !resetLine
                           : q.cfgMask[BIT_RESET_INVERT];
          d.phase        = PH_RESET;
          d.pulseCnt     = RESET_TICKS;
          d.restartAfter = 1'b1;
          d.resetOut     = drvLevel;
          d.resetOe      = 1'b1;
        end
        else if ((q.cfgMask[BIT_KEY_POWER_ON] && !sense && confirmKey && tick
                  && q.confirmCnt == HOLD_SHORT_TICKS - 8'h01) ||
                 (q.cfgMask[BIT_KEY_POWER_OFF] && sense && cancelKey && tick
                  && q.cancelCnt == HOLD_LONG_TICKS - 8'h01))
        begin
          drvLevel       = q.cfgMask[BIT_AUTO_POLARITY] ? !powerLine
                           : q.cfgMask[BIT_POWER_INVERT];
          d.phase        = PH_POWER;
          d.holdMode     = (q.pulseLen == PULSE_HOLD);
          d.pulseCnt     = (q.pulseLen == PULSE_HOLD) ? HOLD_MAX_TICKS
                           : (q.pulseLen == 8'h00) ? 9'd1
                           : {1'b0, q.pulseLen};
          d.extendOk     = sense;
          d.extendCnt    = 8'h00;
          d.restartAfter = !sense;
          d.senseAtStart = sense;
          d.powerOut     = drvLevel;
          d.powerOe      = 1'b1;
        end
        else if (q.cfgMask[BIT_BLANK_HOST] && sense && !q.senseLast)
        begin
          d.phase = PH_RESTART;
        end
      end

      PH_RESET:
      begin
        // fixed length host reset pulse
        if (tick)
          d.pulseCnt = q.pulseCnt - 9'd1;
        if (tick && q.pulseCnt == 9'd1)
        begin
          d.resetOe  = 1'b0;
          d.resetOut = 1'b0;
          d.phase    = PH_RESTART;
        end
      end

      PH_POWER:
      begin
        if (q.pulseCnt != 9'd0 && !(q.holdMode && sense != q.senseAtStart))
        begin
          // base pulse still running
          if (tick)
            d.pulseCnt = q.pulseCnt - 9'd1;
        end
        else if (q.extendOk && cancelKey && q.extendCnt < EXTEND_TICKS)
        begin
          // held cancel key stretches the drive
          if (tick)
            d.extendCnt = q.extendCnt + 8'h01;
        end
        else
        begin
          d.powerOe  = 1'b0;
          d.powerOut = 1'b0;
          d.pulseCnt = 9'd0;
          d.phase    = q.restartAfter ? PH_RESTART : PH_IDLE;
        end
      end

      PH_RESTART:
      begin
        // reload boot settings, watchdog off
        d.cfgMask     = q.bootMask;
        d.pulseLen    = q.bootPulse;
        d.wdTimeout   = 8'h00;
        d.wdCount     = 8'h00;
        d.wdSub       = 5'h00;
        d.confirmCnt  = 8'h00;
        d.cancelCnt   = 8'h00;
        d.selfRestart = 1'b1;
        d.phase       = PH_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q           <= '0;
      q.phase     <= PH_IDLE;
      q.cfgMask   <= MASK_RESET;
      q.pulseLen  <= PULSE_RESET;
      q.bootMask  <= MASK_RESET;
      q.bootPulse <= PULSE_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  assign rdData       = q.rdData;
  assign resetOut     = q.resetOut;
  assign resetOe      = q.resetOe;
  assign powerOut     = q.powerOut;
  assign powerOe      = q.powerOe;
  assign displayDark  = q.displayDark;
  assign backlightOff = q.backlightOff;
  assign ledsOff      = q.ledsOff;
  assign selfRestart  = q.selfRestart;

endmodule

// ==== test/host_model.sv ====
`timescale 1ns/1ns
// ==========================================================
// host board: sense pin and the two pulled control lines
module host_model
#(
  parameter logic PULL_LEVEL = 1'b1 // level of a released control line
)
(
  input  wire logic resetOut,
  input  wire logic resetOe,
  input  wire logic powerOut,
  input  wire logic powerOe,
  input  wire logic hostOn,
  output logic      resetIn,
  output logic      powerIn,
  output logic      hostSense
);
  // released line returns to the board's pull level
  assign resetIn = resetOe ? resetOut : PULL_LEVEL;
  assign powerIn = powerOe ? powerOut : PULL_LEVEL;
  // sense pin pulled up by a running host, driven low when off
  assign hostSense = hostOn;
endmodule

// ==== test/atx_power_switch_watchdog_chk.sv ====
`timescale 1ns/1ns
module atx_power_switch_watchdog_chk
  import atx_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES // cycles per tick
)
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [5:0] addr,
  input wire logic [7:0] wrData,
  input wire logic       wrEn,
  input wire logic       rdEn,
  input wire logic [7:0] rdData,
  input wire logic       hostSense,
  input wire logic       keyConfirm,
  input wire logic       keyCancel,
  input wire logic       resetIn,
  input wire logic       resetOut,
  input wire logic       resetOe,
  input wire logic       powerIn,
  input wire logic       powerOut,
  input wire logic       powerOe,
  input wire logic       displayDark,
  input wire logic       backlightOff,
  input wire logic       ledsOff,
  input wire logic       selfRestart
);
  int unsigned rstLen_q; // cycles reset line driven
  int unsigned pwrLen_q; // cycles power line driven

  // ==========================================================
  // pulse length counters
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rstLen_q <= 0;
      pwrLen_q <= 0;
    end
    else
    begin
      rstLen_q <= resetOe ? rstLen_q + 1 : 0;
      pwrLen_q <= powerOe ? pwrLen_q + 1 : 0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // pulse, restart, line drive, display and read data checks
  sequence restart_seq;
    ##[0:3] selfRestart;
  endsequence

  reset_len_a: assert property ($fell(resetOe) |->
    rstLen_q >= 31 * TICK_CYC && rstLen_q <= 33 * TICK_CYC) else $error("reset pulse length");
  power_max_a: assert property (powerOe |-> pwrLen_q <= 417 * TICK_CYC)
    else $error("power pulse too long");
  restart_follow_a: assert property ($fell(resetOe) |-> restart_seq)
    else $error("no restart after reset pulse");
  restart_once_a: assert property (selfRestart |=> !selfRestart)
    else $error("restart pulse too long");
  reset_level_a: assert property (resetOe && $past(resetOe) |-> $stable(resetOut))
    else $error("reset level moved");
  power_level_a: assert property (powerOe && $past(powerOe) |-> $stable(powerOut))
    else $error("power level moved");
  one_line_a: assert property (!(resetOe && powerOe))
    else $error("both lines driven");
  dark_pair_a: assert property (displayDark == backlightOff)
    else $error("backlight differs from display");
  leds_dark_a: assert property (ledsOff |-> displayDark)
    else $error("leds off without blanking");
  rd_stands_a: assert property (!$past(rdEn) |-> rdData == 8'h00)
    else $error("read data outside its cycle");
  reset_seen_c: cover property ($rose(resetOe));
endmodule

bind atx_power_switch_watchdog atx_power_switch_watchdog_chk #(.TICK_CYC(TICK_CYC)) chk (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
  .rdData(rdData), .hostSense(hostSense), .keyConfirm(keyConfirm), .keyCancel(keyCancel),
  .resetIn(resetIn), .resetOut(resetOut), .resetOe(resetOe), .powerIn(powerIn),
  .powerOut(powerOut), .powerOe(powerOe), .displayDark(displayDark),
  .backlightOff(backlightOff), .ledsOff(ledsOff), .selfRestart(selfRestart));

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
module tb_top
  import atx_pkg::*;
;
  localparam int TC = 4; // cycles per tick in simulation
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wrData = 8'h00;
  logic       wrEn = 1'b0;
  logic       rdEn = 1'b0;
  logic       hostOn = 1'b0;
  logic       keyConfirm = 1'b0;
  logic       keyCancel = 1'b0;
  logic [7:0] rdData;
  logic       hostSense, resetIn, resetOut, resetOe, powerIn, powerOut, powerOe;
  logic       displayDark, backlightOff, ledsOff, selfRestart;
  int         nErrors = 0;
  int         compares = 0;

  always #4 clk = ~clk;

  atx_power_switch_watchdog #(.TICK_CYC(TC)) uut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .hostSense(hostSense),
    .keyConfirm(keyConfirm), .keyCancel(keyCancel), .resetIn(resetIn), .resetOut(resetOut),
    .resetOe(resetOe), .powerIn(powerIn), .powerOut(powerOut), .powerOe(powerOe),
    .displayDark(displayDark), .backlightOff(backlightOff), .ledsOff(ledsOff),
    .selfRestart(selfRestart));
  host_model hm (.resetOut(resetOut), .resetOe(resetOe), .powerOut(powerOut),
    .powerOe(powerOe), .hostOn(hostOn), .resetIn(resetIn), .powerIn(powerIn),
    .hostSense(hostSense));

  // ==========================================================
  // report and access tasks
  task automatic tally_and_finish();
    if (nErrors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // count within a tolerance, for tick phase and pin sync lag
  task automatic near(input string what, input int exp, input int tol, input int got);
    compares++;
    if (got < exp - tol || got > exp + tol)
    begin
      nErrors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    chk(what, {8'h00, exp}, {8'h00, rdData});
  endtask

  task automatic cmd(input logic [7:0] code, input logic [7:0] a0, input logic [7:0] a1,
                     input logic [7:0] cnt);
    wr(REG_ARG0, a0);
    wr(REG_ARG1, a1);
    wr(REG_ARGCNT, cnt);
    wr(REG_CMD, code);
  endtask

  function automatic logic sig(input int i);
    case (i)
      0: sig = resetOe;
      1: sig = powerOe;
      default: sig = selfRestart;
    endcase
  endfunction

  // bounded wait for a pin to reach a level, n counts cycles
  task automatic waitSig(input int i, input logic lvl, input int lim, output int n);
    n = 0;
    while (sig(i) !== lvl && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= lim)
    begin
      nErrors++;
      $display("CHECK FAILED wait pin %0d expected %b seen timeout", i, lvl);
      tally_and_finish();
    end
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    int n;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    rd(REG_BOOT_MASK, 8'h00, "boot mask");
    rd(REG_BOOT_PULSE, 8'hff, "boot pulse");
    rd(REG_STAT_BASE + STAT_WDOG_IDX, 8'h00, "wdog count");
    rd(6'h3f, 8'h00, "unmapped");
    // leds bit alone does nothing, then full blanking
    cmd(CMD_SWITCH, 8'h08, 8'h00, 8'h01);
    rd(REG_RESP, RESP_SWITCH, "switch ack");
    cyc(6);
    chk("leds alone", 16'h0000, {13'h0, displayDark, backlightOff, ledsOff});
    cmd(CMD_SWITCH, 8'h18, 8'h00, 8'h01);
    cyc(6);
    chk("blanked", 16'h0007, {13'h0, displayDark, backlightOff, ledsOff});
    rd(REG_STAT_BASE + STAT_MASK_IDX, 8'h18, "status mask");
    @(posedge clk);
    hostOn <= 1'b1;
    waitSig(2, 1'b1, 20, n);
    cyc(4);
    chk("unblanked", 16'h0000, {13'h0, displayDark, backlightOff, ledsOff});
    rd(REG_STAT_BASE + STAT_MASK_IDX, 8'h00, "boot reload");
    // status and unknown codes
    wr(REG_CMD, CMD_STATUS);
    rd(REG_RESP, RESP_STATUS, "status ack");
    wr(REG_CMD, 8'h33);
    rd(REG_RESP, 8'hb3, "unknown ack");
    // keypad reset, inverted drive
    cmd(CMD_SWITCH, 8'h22, 8'h00, 8'h01);
    @(posedge clk);
    keyConfirm <= 1'b1;
    waitSig(0, 1'b1, 140 * TC, n);
    near("reset hold", 128 * TC, TC + 4, n);
    chk("reset level", 16'h0001, {15'h0, resetOut});
    @(posedge clk);
    keyConfirm <= 1'b0;
    wr(REG_CMD, CMD_WATCHDOG);
    rd(REG_RESP, RESP_SWITCH, "busy refused");
    waitSig(0, 1'b0, 40 * TC, n);
    // five edges went to the key release and the refused command
    near("reset len", 32 * TC, TC, n + 5);
    waitSig(2, 1'b1, 4, n);
    // watchdog refresh, expiry, then stays off
    cmd(CMD_WATCHDOG, 8'h01, 8'h00, 8'h01);
    rd(REG_RESP, RESP_WATCHDOG, "wdog ack");
    rd(REG_STAT_BASE + STAT_WDOG_IDX, 8'h01, "wdog count");
    cyc(20 * TC);
    wr(REG_CMD, CMD_WATCHDOG);
    cyc(20 * TC);
    chk("wdog refreshed", 16'h0000, {15'h0, resetOe});
    waitSig(0, 1'b1, 40 * TC, n);
    chk("wdog level", 16'h0000, {15'h0, resetOut});
    waitSig(0, 1'b0, 40 * TC, n);
    waitSig(2, 1'b1, 4, n);
    cyc(40 * TC);
    chk("wdog off", 16'h0000, {15'h0, resetOe});
    rd(REG_STAT_BASE + STAT_WDOG_IDX, 8'h00, "wdog cleared");
    // keypad power-on, 3 tick pulse driven high
    @(posedge clk);
    hostOn <= 1'b0;
    cmd(CMD_SWITCH, 8'h44, 8'h03, 8'h02);
    @(posedge clk);
    keyConfirm <= 1'b1;
    waitSig(1, 1'b1, 12 * TC, n);
    near("on hold", 8 * TC, TC + 4, n);
    chk("on level", 16'h0001, {15'h0, powerOut});
    @(posedge clk);
    keyConfirm <= 1'b0;
    waitSig(1, 1'b0, 10 * TC, n);
    near("on len", 3 * TC, TC, n);
    waitSig(2, 1'b1, 4, n);
    // default length holds until the host sense changes
    cmd(CMD_SWITCH, 8'h40, 8'h00, 8'h01);
    @(posedge clk);
    keyConfirm <= 1'b1;
    waitSig(1, 1'b1, 12 * TC, n);
    chk("hold level", 16'h0000, {15'h0, powerOut});
    cyc(20 * TC);
    chk("hold stands", 16'h0001, {15'h0, powerOe});
    @(posedge clk);
    hostOn <= 1'b1;
    keyConfirm <= 1'b0;
    waitSig(1, 1'b0, 8, n);
    near("hold end", 3, 1, n);
    waitSig(2, 1'b1, 4, n);
    // keypad power-off, auto polarity, held for extension
    @(posedge clk);
    hostOn <= 1'b1;
    cmd(CMD_SWITCH, 8'h81, 8'h02, 8'h02);
    @(posedge clk);
    keyCancel <= 1'b1;
    waitSig(1, 1'b1, 140 * TC, n);
    near("off hold", 128 * TC, TC + 4, n);
    chk("auto level", 16'h0000, {15'h0, powerOut});
    waitSig(1, 1'b0, 170 * TC, n);
    near("off extend", 162 * TC, 2 * TC, n);
    @(posedge clk);
    keyCancel <= 1'b0;
    cyc(4);
    tally_and_finish();
  end
endmodule
